// File: tpp_pkg.sv
// Package with constants and types of the transmit payload input interface
`default_nettype none

package tpp_pkg;

   // =========================================================
   // Register map (byte addresses)
   // =========================================================
   localparam logic [7:0] TPP_CTRL_OFS   = 8'h00; // Timing mode, run enable
   localparam logic [7:0] TPP_STATUS_OFS = 8'h04; // Effective mode number
   localparam logic [7:0] TPP_FRAMES_OFS = 8'h08; // Completed frame count

   // =========================================================
   // Field positions and reset values
   // =========================================================
   localparam int TPP_CTRL_TIM_LSB = 0;        // Timing select, 2 bits
   localparam int TPP_CTRL_EN_BIT  = 2;        // Run enable
   localparam int TPP_STAT_NIB_BIT = 3;        // Nibble path selected
   localparam logic       TPP_EN_RST     = 1'b1;
   localparam logic [1:0] TPP_TIMING_RST = 2'h0;

   // =========================================================
   // AXI responses
   // =========================================================
   localparam logic [1:0] TPP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TPP_RESP_DECERR = 2'h3;

   // =========================================================
   // Frame geometry: 56 blocks of one overhead and 84 payload bits
   // =========================================================
   localparam logic [6:0]  TPP_BLK_LAST = 7'h54;   // 84
   localparam logic [5:0]  TPP_GRP_LAST = 6'h37;   // 55
   localparam logic [10:0] TPP_NIB_LAST = 11'h497; // 1175
   localparam logic [2:0]  TPP_SERIAL_BASE = 3'h1; // Modes 1..3
   localparam logic [2:0]  TPP_NIBBLE_BASE = 3'h4; // Modes 4..6

   // =========================================================
   // Types
   // =========================================================
   typedef enum logic [1:0] {
      TPP_LOOP   = 2'h0,  // Loop-timed from recovered line clock
      TPP_SLAVE  = 2'h1,  // Local-timed, frame slave
      TPP_MASTER = 2'h2   // Local-timed, frame master
   } tpp_timing_type;

   typedef struct packed {
      logic           en;
      tpp_timing_type timing;
   } tpp_cfg_type;

   typedef struct packed {
      logic       valid;   // One link cycle per captured item
      logic       nibble;  // Data holds a nibble, else bit 0 only
      logic [3:0] data;
   } tpp_payload_type;

endpackage

`default_nettype wire

// File: tpp_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`default_nettype none

module tpp_sync
   import tpp_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   // =========================================================
   // Synchroniser stages
   // =========================================================
   logic [WIDTH-1:0] meta_reg;   // First stage, read only by q

   // Both stages clear on reset; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// File: tpp_tx_payload.sv
// Transmit payload input interface with AXI4-Lite control
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`default_nettype none

module tpp_tx_payload
   import tpp_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            srst,
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output var  logic            s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output var  logic            s_axi_wready,
   output var  logic [1:0]      s_axi_bresp,
   output var  logic            s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output var  logic            s_axi_arready,
   output var  logic [31:0]     s_axi_rdata,
   output var  logic [1:0]      s_axi_rresp,
   output var  logic            s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic            tx_timing_clk,
   input  wire logic            serial_payload_in,
   input  wire logic [3:0]      nibble_payload_in,
   input  wire logic            nibble_select,
   input  wire logic            frame_start_ref_in,
   output var  logic            overhead_warn_out,
   output var  logic            frame_end_pulse,
   output var  logic            loop_clock_out,
   output var  logic            nibble_clock_out,
   output var  logic            nibble_frame_end_pulse,
   output var  logic            timing_select_out,
   output var  tpp_payload_type payload_out
);

   // =========================================================
   // System domain: register state
   // =========================================================
   tpp_cfg_type cfg_reg;          // Software control
   logic [31:0] frames_reg;       // Frames completed on the link
   logic        aw_held;          // Write address taken, not answered
   logic        w_held;           // Write data taken, not answered
   logic [7:0]  awaddr_reg;       // Held write address
   logic [31:0] wdata_reg;        // Held write data
   logic [3:0]  wstrb_reg;        // Held byte strobes
   logic        nib_sys;          // Nibble select seen by system side
   logic        done_tgl_sys;     // Frame toggle after crossing
   logic        done_tgl_old;     // Previous toggle for edge detect

   // =========================================================
   // System domain: decode
   // =========================================================
   wire         do_write   = aw_held & w_held & ~s_axi_bvalid;
   wire [7:0]   wr_word    = {awaddr_reg[7:2], 2'b00};
   wire [7:0]   rd_word    = {s_axi_araddr[7:2], 2'b00};
   wire         wr_ctrl    = do_write & (wr_word == TPP_CTRL_OFS);
   wire         wr_known   = (wr_word == TPP_CTRL_OFS) |
                             (wr_word == TPP_STATUS_OFS) |
                             (wr_word == TPP_FRAMES_OFS);
   wire         rd_ctrl    = rd_word == TPP_CTRL_OFS;
   wire         rd_status  = rd_word == TPP_STATUS_OFS;
   wire         rd_frames  = rd_word == TPP_FRAMES_OFS;
   wire         rd_known   = rd_ctrl | rd_status | rd_frames;
   wire         ar_take    = s_axi_arvalid & s_axi_arready;
   wire [1:0]   new_timing = wdata_reg[TPP_CTRL_TIM_LSB +: 2];
   // Timing code 3 names no mode, so it is refused
   wire         timing_ok  = new_timing != 2'h3;
   wire         frame_done = done_tgl_sys ^ done_tgl_old;
   // Mode number: serial base or nibble base plus timing code
   wire [2:0]   mode_num   = (nib_sys ? TPP_NIBBLE_BASE
                                      : TPP_SERIAL_BASE) +
                             {1'b0, cfg_reg.timing};
   wire [31:0]  ctrl_word  = {29'h0, cfg_reg.en, cfg_reg.timing};
   wire [31:0]  stat_word  = {28'h0, nib_sys, mode_num};
   wire [31:0]  rd_mux     = rd_ctrl   ? ctrl_word :
                             rd_status ? stat_word :
                             rd_frames ? frames_reg : 32'h0;

   // =========================================================
   // System domain: write address and data channels
   // =========================================================
   // Each channel is taken alone and held until the answer leaves
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         aw_held    <= 1'b0;
         awaddr_reg <= 8'h00;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_held    <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
      end else if (s_axi_bvalid & s_axi_bready) begin
         aw_held    <= 1'b0;
      end
   end

   // Write data latch
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         w_held    <= 1'b0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_held    <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (s_axi_bvalid & s_axi_bready) begin
         w_held    <= 1'b0;
      end
   end

   // Ready flags are registered; low while a channel is held
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         s_axi_awready <= ~(aw_held | (s_axi_awvalid & s_axi_awready)) |
                          (s_axi_bvalid & s_axi_bready);
         s_axi_wready  <= ~(w_held | (s_axi_wvalid & s_axi_wready)) |
                          (s_axi_bvalid & s_axi_bready);
      end
   end

   // =========================================================
   // System domain: write response and control register
   // =========================================================
   // Response one edge after both halves are held
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TPP_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? TPP_RESP_OKAY : TPP_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only byte lane 0 carries control fields
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_reg.en     <= TPP_EN_RST;
         cfg_reg.timing <= tpp_timing_type'(TPP_TIMING_RST);
      end else if (wr_ctrl & wstrb_reg[0]) begin
         cfg_reg.en <= wdata_reg[TPP_CTRL_EN_BIT];
         if (timing_ok) begin
            cfg_reg.timing <= tpp_timing_type'(new_timing);
         end
      end
   end

   // =========================================================
   // System domain: read channel
   // =========================================================
   // Data captured at the address handshake, held until taken
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= TPP_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_known ? TPP_RESP_OKAY : TPP_RESP_DECERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // =========================================================
   // System domain: crossings in and frame counting
   // =========================================================
   logic link_tgl;                // Frame toggle in link domain

   // Pin level for the status view
   tpp_sync #(.WIDTH(1)) u_nib_sys (
      .clk (clk_sys),
      .rst (srst),
      .d   (nibble_select),
      .q   (nib_sys)
   );

   // Frame completion event arrives as a toggle
   tpp_sync #(.WIDTH(1)) u_done_sys (
      .clk (clk_sys),
      .rst (srst),
      .d   (link_tgl),
      .q   (done_tgl_sys)
   );

   // Counter wraps silently after 2^32 frames
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         done_tgl_old <= 1'b0;
         frames_reg   <= 32'h0;
      end else begin
         done_tgl_old <= done_tgl_sys;
         if (frame_done) begin
            frames_reg <= frames_reg + 32'h1;
         end
      end
   end

   // Board clock mux select: high picks the local transmit clock
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         timing_select_out <= 1'b0;
      end else begin
         timing_select_out <= cfg_reg.timing != TPP_LOOP;
      end
   end

   // =========================================================
   // Link domain: reset and inputs
   // =========================================================
   logic        link_rst;         // Reset carried into link domain
   tpp_cfg_type cfg_link;         // Quasi-static control copy
   logic        nib_link;         // Nibble path selected
   logic        ref_link;         // Frame reference level
   logic        ref_old;          // Previous reference level
   logic        ser_link;         // Serial payload bit
   logic [3:0]  nib_data_link;    // Nibble payload

   // Reset synchroniser has no reset of its own
   tpp_sync #(.WIDTH(1)) u_rst_link (
      .clk (tx_timing_clk),
      .rst (1'b0),
      .d   (srst),
      .q   (link_rst)
   );

   // Control changes only while software reconfigures
   tpp_sync #(.WIDTH(3)) u_cfg_link (
      .clk (tx_timing_clk),
      .rst (link_rst),
      .d   (cfg_reg),
      .q   (cfg_link)
   );

   // All terminal pins enter through two flops
   tpp_sync #(.WIDTH(7)) u_pins_link (
      .clk (tx_timing_clk),
      .rst (link_rst),
      .d   ({nibble_select, frame_start_ref_in, serial_payload_in,
             nibble_payload_in}),
      .q   ({nib_link, ref_link, ser_link, nib_data_link})
   );

   // =========================================================
   // Link domain: frame counters state
   // =========================================================
   logic        phase_reg;        // Half of the bit period
   logic [6:0]  blk_cnt_reg;      // Bit within block, 0 is overhead
   logic [5:0]  grp_cnt_reg;      // Block within frame
   logic [1:0]  pay_cnt_reg;      // Payload bit within nibble
   logic [10:0] nib_cnt_reg;      // Nibble within frame

   // =========================================================
   // Link domain: next-state decode
   // =========================================================
   wire         run        = cfg_link.en;
   wire         loop_mode  = cfg_link.timing == TPP_LOOP;
   wire         slave_mode = cfg_link.timing == TPP_SLAVE;
   wire         ref_rise   = ref_link & ~ref_old;
   // Reference only counts in slave mode; master runs free
   wire         restart    = run & slave_mode & ref_rise;
   wire         bit_end    = run & phase_reg;
   wire         is_oh      = blk_cnt_reg == 7'h00;
   wire         last_blk   = blk_cnt_reg == TPP_BLK_LAST;
   wire         last_grp   = grp_cnt_reg == TPP_GRP_LAST;
   wire         last_nib   = nib_cnt_reg == TPP_NIB_LAST;
   wire         pay_end    = bit_end & ~is_oh;
   wire         nib_step   = pay_end & (pay_cnt_reg == 2'h3);
   wire         frame_wrap = bit_end & last_blk & last_grp;
   wire         phase_next = ~restart & run & ~phase_reg;
   wire [6:0]   blk_next   = restart ? 7'h00 :
                             ~bit_end ? blk_cnt_reg :
                             last_blk ? 7'h00 : blk_cnt_reg + 7'h01;
   wire [5:0]   grp_next   = restart ? 6'h00 :
                             ~(bit_end & last_blk) ? grp_cnt_reg :
                             last_grp ? 6'h00 : grp_cnt_reg + 6'h01;
   wire [1:0]   pay_next   = restart ? 2'h0 :
                             pay_end ? pay_cnt_reg + 2'h1 : pay_cnt_reg;
   wire [10:0]  nib_next   = restart ? 11'h000 :
                             ~nib_step ? nib_cnt_reg :
                             last_nib ? 11'h000 : nib_cnt_reg + 11'h001;
   // Serial capture at the edge where the loop clock rises
   wire         cap_ser    = run & ~nib_link & ~phase_reg & ~is_oh;
   // Nibble capture at the edge where the nibble clock rises
   wire         cap_nib    = run & nib_link & nib_step;

   // =========================================================
   // Link domain: counters
   // =========================================================
   // Counts hold and the bit phase clears while disabled, then resume
   always_ff @(posedge tx_timing_clk) begin
      if (link_rst) begin
         phase_reg   <= 1'b0;
         blk_cnt_reg <= 7'h00;
         grp_cnt_reg <= 6'h00;
         pay_cnt_reg <= 2'h0;
         nib_cnt_reg <= 11'h000;
         ref_old     <= 1'b0;
      end else begin
         phase_reg   <= phase_next;
         blk_cnt_reg <= blk_next;
         grp_cnt_reg <= grp_next;
         pay_cnt_reg <= pay_next;
         nib_cnt_reg <= nib_next;
         ref_old     <= ref_link;
      end
   end

   // =========================================================
   // Link domain: terminal outputs
   // =========================================================
   // Built from next counts so the warn and frame end pulses each stay a whole bit period
   always_ff @(posedge tx_timing_clk) begin
      if (link_rst) begin
         overhead_warn_out      <= 1'b0;
         frame_end_pulse        <= 1'b0;
         loop_clock_out         <= 1'b0;
         nibble_clock_out       <= 1'b0;
         nibble_frame_end_pulse <= 1'b0;
      end else begin
         overhead_warn_out      <= run & ~nib_link &
                                   (blk_next == TPP_BLK_LAST);
         frame_end_pulse        <= run & (blk_next == TPP_BLK_LAST) &
                                   (grp_next == TPP_GRP_LAST);
         loop_clock_out         <= run & loop_mode & phase_next;
         nibble_clock_out       <= run & nib_link & ~pay_next[1];
         nibble_frame_end_pulse <= run & nib_link &
                                   (nib_next == TPP_NIB_LAST);
      end
   end

   // =========================================================
   // Link domain: payload capture and frame event
   // =========================================================
   // Overhead periods yield no payload item
   always_ff @(posedge tx_timing_clk) begin
      if (link_rst) begin
         payload_out <= '0;
      end else begin
         payload_out.valid  <= cap_ser | cap_nib;
         payload_out.nibble <= nib_link;
         payload_out.data   <= nib_link ? nib_data_link
                                        : {3'h0, ser_link};
      end
   end

   // One toggle per completed frame, counted on the system side
   always_ff @(posedge tx_timing_clk) begin
      if (link_rst) begin
         link_tgl <= 1'b0;
      end else if (frame_wrap & ~restart) begin
         link_tgl <= ~link_tgl;
      end
   end

endmodule

`default_nettype wire

// File: tpp_tx_payload_checker.sv
// Link-side assertions for the transmit payload interface
`default_nettype none
module tpp_tx_payload_checker
   import tpp_pkg::*;
(
   input  wire logic            tx_timing_clk,
   input  wire logic            srst,
   input  wire logic            nibble_select,
   input  wire logic            timing_select_out,
   input  wire logic            overhead_warn_out,
   input  wire logic            frame_end_pulse,
   input  wire logic            loop_clock_out,
   input  wire logic            nibble_clock_out,
   input  wire logic            nibble_frame_end_pulse,
   input  wire tpp_payload_type payload_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Link domain properties
   default clocking cb @(posedge tx_timing_clk); endclocking
   default disable iff (srst);
   // Mode switch to nibble may cut a pulse, so skip while selected
   property p_warn_len;
      disable iff (srst || nibble_select)
      $rose(overhead_warn_out) && !$past(nibble_select, 4)
         |=> overhead_warn_out ##1 !overhead_warn_out;
   endproperty
   a_warn_len: assert property (p_warn_len) else $error("warn width");
   // The overhead slot yields no captured payload
   property p_ovh_skip;
      $fell(overhead_warn_out) && !nibble_select
         |-> ##1 !payload_out.valid ##1 !payload_out.valid;
   endproperty
   a_ovh_skip: assert property (p_ovh_skip) else $error("ovh taken");
   property p_nib_quiet;
      nibble_clock_out || nibble_frame_end_pulse |-> !overhead_warn_out;
   endproperty
   a_nib_quiet: assert property (p_nib_quiet) else $error("warn nib");
   property p_fend_len;
      $rose(frame_end_pulse) |=> frame_end_pulse ##1 !frame_end_pulse;
   endproperty
   a_fend_len: assert property (p_fend_len) else $error("fend width");
   property p_loopclk;
      loop_clock_out |=> !loop_clock_out;
   endproperty
   a_loopclk: assert property (p_loopclk) else $error("loop clk");
   property p_loop_local;
      timing_select_out [*8] |-> !loop_clock_out;
   endproperty
   a_loop_local: assert property (p_loop_local) else $error("loop clk");
   property p_nclk;
      disable iff (srst || !nibble_select)
      // Path switch lags the pin; a rise at switch-on may be short
      $rose(nibble_clock_out) && $past(nibble_select, 4)
         |-> nibble_clock_out [*4];
   endproperty
   a_nclk: assert property (p_nclk) else $error("nib clk");
   property p_nfend;
      disable iff (srst || !nibble_select)
      $rose(nibble_frame_end_pulse) && $past(nibble_select, 4)
         |-> nibble_frame_end_pulse [*8]
         ##[1:3] !nibble_frame_end_pulse;
   endproperty
   a_nfend: assert property (p_nfend) else $error("nib end");
endmodule
`default_nettype wire

// File: tpp_terminal_model.sv
// Terminal equipment model feeding the payload interface
`default_nettype none
module tpp_terminal_model (
   input  wire logic       tx_timing_clk,
   input  wire logic       overhead_warn_out,
   input  wire logic       frame_end_pulse,
   input  wire logic       nibble_frame_end_pulse,
   input  wire logic       ref_go,
   output var  logic       serial_payload_in,
   output var  logic [3:0] nibble_payload_in,
   output var  logic       frame_start_ref_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Own bit clock, payload sequence, reference pulse
   logic [7:0] seq_reg = 8'h00; // Payload sequence
   logic       ph_reg  = 1'b0;  // Bit phase of the shared clock
   logic       go_reg  = 1'b0;  // Last request level seen
   logic [1:0] ref_reg = 2'h0;  // Reference cycles left
   always_ff @(posedge tx_timing_clk) begin
      ph_reg <= !ph_reg;
      go_reg <= ref_go;
      if (go_reg != ref_go) ref_reg <= 2'h2; // One bit long
      else if (ref_reg != 2'h0) ref_reg <= ref_reg - 2'h1;
      if (frame_end_pulse || nibble_frame_end_pulse) seq_reg <= 8'h00;
      else if (ph_reg && !overhead_warn_out) seq_reg <= seq_reg + 8'h01;
   end
   // Serial data changes on seven sequence steps in eight, nibble data every second step, so a stale sample shows
   assign serial_payload_in  = seq_reg[0] ^ seq_reg[3];
   assign nibble_payload_in  = seq_reg[4:1];
   assign frame_start_ref_in = ref_reg != 2'h0;
endmodule
`default_nettype wire

// File: tpp_tx_payload_tb.sv
// Testbench of the transmit payload interface
`default_nettype none
module tpp_tx_payload_tb
   import tpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Signals and counters
   localparam int BITS = (TPP_GRP_LAST + 1) * (TPP_BLK_LAST + 1);
   logic clk_sys = 1'b0, srst = 1'b1, tx_timing_clk = 1'b0, ref_go = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, nibble_payload_in;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nibble_select = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, serial_payload_in, frame_start_ref_in;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic overhead_warn_out, frame_end_pulse, loop_clock_out, timing_select_out;
   logic nibble_clock_out, nibble_frame_end_pulse;
   tpp_payload_type payload_out;
   int n_mismatch = 0, checks_done = 0, cycles = 0;
   int n [5]; // Cycles, warn, valid, nibble clock, loop clock
   wire [3:0] stopv = {1'b0, nibble_frame_end_pulse, frame_end_pulse,
                       overhead_warn_out};
   // Every port has a bench signal of the same name
   tpp_tx_payload tpp_tx_payload_inst (.*);
   tpp_terminal_model tpp_terminal_model_inst (.*);
   // ==========
   // Clocks: shared DS3-rate reference stands in for the board mux
   initial forever #10 clk_sys = !clk_sys;
   initial begin
      #7;
      forever #40 tx_timing_clk = !tx_timing_clk;
   end
   // ==========
   // Helpers
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] e);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, e});
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] e);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      check("rdata", s_axi_rdata, d);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, e});
      s_axi_rready <= 1'b0;
   endtask
   // Count link edges until the chosen stop next rises, or a cap
   task automatic run_win(input int sel, input int cap);
      logic ps, pw, pn, pl;
      n = '{default: 0};
      do begin
         ps = stopv[sel];
         pw = overhead_warn_out;
         pn = nibble_clock_out;
         pl = loop_clock_out;
         @(posedge tx_timing_clk);
         n[0]++;
         n[1] += int'(overhead_warn_out & !pw);
         n[2] += int'(payload_out.valid);
         n[3] += int'(nibble_clock_out & !pn);
         n[4] += int'(loop_clock_out & !pl);
      end while (!(stopv[sel] && !ps) && n[0] != cap);
   endtask
   task automatic set_tim(input logic [1:0] t);
      wr_chk(TPP_CTRL_OFS, {29'h0, 1'b1, t}, TPP_RESP_OKAY);
      repeat (40) @(posedge clk_sys);
   endtask
   // ==========
   // Scenarios
   task automatic t_regs();
      rd_chk(TPP_CTRL_OFS, {29'h0, TPP_EN_RST, TPP_TIMING_RST}, TPP_RESP_OKAY);
      rd_chk(8'h0C, 32'h0, TPP_RESP_DECERR);
      wr_chk(8'h0C, 32'h0, TPP_RESP_DECERR);
      wr_chk(TPP_CTRL_OFS, 32'h0000_0007, TPP_RESP_OKAY);
      rd_chk(TPP_CTRL_OFS, 32'h0000_0004, TPP_RESP_OKAY);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 6; m++) begin
         nibble_select <= (m > 2);
         set_tim(2'(m % 3));
         rd_chk(TPP_STATUS_OFS, {28'h0, m > 2, 3'(m + 1)}, TPP_RESP_OKAY);
      end
      nibble_select <= 1'b0;
   endtask
   task automatic t_link();
      set_tim(2'h0);
      run_win(3, 101); // First sample repeats, so 101 give 100 steps
      check("loop rises", n[4], 32'd50);
      set_tim(2'h1);
      run_win(3, 100);
      check("local loop rises", n[4], 32'd0);
      set_tim(2'h2);
      run_win(0, 400);
      ref_go <= !ref_go;
      run_win(0, 400);
      check("master block", n[0], 32'd170);
      check("block payload", n[2], 32'd84);
      set_tim(2'h1);
      run_win(0, 400);
      ref_go <= !ref_go;
      run_win(1, 10000);
      check("frame warns", n[1], 32'd56);
      check("restart", n[0] inside {[2 * BITS - 2 : 2 * BITS + 10]}, 1);
      nibble_select <= 1'b1;
      run_win(3, 8);
      run_win(2, 10000);
      check("nibble rises", n[3], 32'(BITS / 4 - 14 - 1));
      check("nibble warns", n[1], 32'd0);
   endtask
   // ==========
   // Main sequence and hang guard
   initial begin
      repeat (5) @(posedge tx_timing_clk);
      @(posedge clk_sys);
      srst <= 1'b0;
      t_regs();
      t_modes();
      t_link();
      give_verdict();
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         n_mismatch++;
         give_verdict();
      end
   end
endmodule
bind tpp_tx_payload tpp_tx_payload_checker tpp_tx_payload_checker_inst (.*);
`default_nettype wire
